//--- pbs_burst_cnt.sv
// burst address counter with linear and interleaved order
`timescale 1ns/100ps
`include "pbs_cfg.svh"
module pbs_burst_cnt (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_load,
    input  wire logic [`PBS_LOW_W-1:0] i_start,
    input  wire logic                 i_advance,
    input  wire logic                 i_order,
    output logic      [`PBS_LOW_W-1:0] o_low
);
    logic [`PBS_LOW_W-1:0] start;
    logic [`PBS_LOW_W-1:0] count;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start <= 2'h0;
            count <= 2'h0;
        end else if (i_load) begin
            start <= i_start;
            count <= 2'h0;
        end else if (i_advance) begin
            count <= count + 2'h1;
        end
    end

    // two-bit count wraps to initial state after the fourth beat
    always_comb begin
        if (i_order == `PBS_ORD_INTLV) begin
            o_low = start ^ count;
        end else begin
            o_low = start + count;
        end
    end
endmodule : pbs_burst_cnt

//--- pbs_cfg.svh
// constants for the pipelined burst sram
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH
`define PBS_AW        17
`define PBS_DEPTH     131072
`define PBS_BYTES     4
`define PBS_BYTE_W    9
`define PBS_LANE_W    8
`define PBS_DATA_W    32
`define PBS_PAR_W     4
`define PBS_WORD_W    36
`define PBS_BEATS     3'h4
`define PBS_LOW_W     2
`define PBS_ORD_INTLV 1'b1
`define PBS_ORD_LIN   1'b0
`endif

//--- pbs_ctrl_model.sv
// bus controller model driving the sram's synchronous inputs
`timescale 1ns/100ps
`include "pbs_cfg.svh"
module pbs_ctrl_model (
    input  wire logic                   i_clk_sys,
    output logic      [`PBS_AW-1:0]     o_addr,
    output logic      [5:0]             o_ctl,
    output logic      [`PBS_BYTES-1:0]  o_bsel_n,
    output logic      [`PBS_WORD_W-1:0] o_wdata
);
    initial begin
        o_addr   = '0;
        o_ctl    = 6'h1f;
        o_bsel_n = '1;
        o_wdata  = '0;
    end
    // ctl is {enable_n, ctrl strobe_n, proc strobe_n, advance_n, global_n, gate_n}
    // changes land on the falling edge, half a period clear of sampling
    task automatic cyc(input logic [5:0] ctl, input logic [16:0] a,
                       input logic [3:0] bs, input logic dv, input logic [35:0] d);
        @(negedge i_clk_sys);
        o_ctl    <= ctl;
        o_addr   <= a;
        o_bsel_n <= bs;
        o_wdata  <= dv ? d : ~o_wdata; // released bus never holds stale data
    endtask : cyc
endmodule : pbs_ctrl_model

//--- pbs_pkg.sv
// types for the pipelined burst sram
package pbs_pkg;
    typedef enum logic [1:0] {
        PBS_OP_IDLE  = 2'b00,
        PBS_OP_READ  = 2'b01,
        PBS_OP_WRITE = 2'b10
    } pbs_op_e;
endpackage : pbs_pkg

//--- pbs_sram.sv
// pipelined burst synchronous sram, 128k words of 36 bits
//
// Behaviour
// - new address on strobe cycle
// - advance low steps counter, high holds
// - four beats per loaded address
// - read data two cycles after address
// - data input and output registered
// - selected only for enable, cs0 high, cs1 low
// - global write writes all bytes
// - byte gate enables byte selects
// - byte select n governs byte n plus parity
// - any byte write disables outputs
// - write self-timed, decided late
// - order select high interleaved, low linear
// - output enable asynchronous, needs selection
// - sleep gates clock, retains contents (the clock runs on here; sleep blocks loads, steps and writes)
// - 128k by 36 organisation, seventeen address inputs
// - boundary scan not implemented here
// - interleaved xor count, wraps
// - linear increments modulo four, wraps
// - processor strobe cycles are reads
// - no strobe: advance and write inputs decide
`timescale 1ns/100ps
`include "pbs_cfg.svh"
module pbs_sram (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    input  wire logic [`PBS_AW-1:0]      i_addr_in,
    input  wire logic                    i_chip_enable_n,
    input  wire logic                    i_chip_select_hi,
    input  wire logic                    i_chip_select_lo_n,
    input  wire logic                    i_ctrl_addr_strobe_n,
    input  wire logic                    i_proc_addr_strobe_n,
    input  wire logic                    i_burst_advance_n,
    input  wire logic                    i_global_write_n,
    input  wire logic                    i_byte_write_gate_n,
    input  wire logic [`PBS_BYTES-1:0]   i_byte_select_n,
    input  wire logic                    i_output_enable_n,
    input  wire logic                    i_burst_order_sel,
    input  wire logic                    i_sleep_req,
    input  wire logic [`PBS_DATA_W-1:0]  i_data_io,
    input  wire logic [`PBS_PAR_W-1:0]   i_parity_io,
    output logic      [`PBS_DATA_W-1:0]  o_data_io,
    output logic      [`PBS_PAR_W-1:0]   o_parity_io,
    output logic                         o_data_oe,
    output logic                         o_sleeping
);
    logic [`PBS_WORD_W-1:0] mem [0:`PBS_DEPTH-1];
    logic                   sleep;
    logic                   sel;
    logic                   proc_load;
    logic                   ctrl_load;
    logic                   load;
    logic                   cont;
    logic [`PBS_BYTES-1:0]  next_wr_bytes;
    logic [`PBS_AW-1:0]     base;
    logic [`PBS_LOW_W-1:0]  low;
    logic [`PBS_AW-1:0]     cur_addr;
    logic                   active;
    logic                   selected;
    logic                   rd_valid;
    logic [`PBS_BYTES-1:0]  wr_bytes;
    logic [`PBS_AW-1:0]     wr_addr;
    logic [`PBS_WORD_W-1:0] wr_data;
    logic                   wr_pend;
    pbs_pkg::pbs_op_e       op;
    logic [`PBS_WORD_W-1:0] rd_word;
    logic                   wr_commit;
    logic [`PBS_BYTES-1:0]  wr_mask;
    logic [`PBS_LOW_W-1:0]  beat_cnt;

    // sleep is asynchronous, so it passes the three-stage synchroniser
    pbs_sync3 u_sleep_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_sleep_req),
        .o_level   (sleep)
    );

    assign o_sleeping = sleep;
    assign sel = !i_chip_enable_n && i_chip_select_hi && !i_chip_select_lo_n;
    assign proc_load = !i_proc_addr_strobe_n && !i_chip_enable_n;
    assign ctrl_load = !i_ctrl_addr_strobe_n;
    assign load = !sleep && (proc_load || ctrl_load);
    assign cont = !sleep && !load && active;

    // write byte decode: global write beats gate and selects
    always_comb begin
        if (proc_load) begin
            next_wr_bytes = '0;
        end else if (!i_global_write_n) begin
            next_wr_bytes = '1;
        end else if (!i_byte_write_gate_n) begin
            next_wr_bytes = ~i_byte_select_n;
        end else begin
            next_wr_bytes = '0;
        end
    end

    pbs_burst_cnt u_burst (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_load    (load),
        .i_start   (i_addr_in[`PBS_LOW_W-1:0]),
        .i_advance (cont && !i_burst_advance_n),
        .i_order   (i_burst_order_sel),
        .o_low     (low)
    );

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            base   <= '0;
            active <= 1'b0;
        end else if (load) begin
            base   <= i_addr_in;
            active <= sel;
        end
    end

    assign cur_addr = {base[`PBS_AW-1:`PBS_LOW_W], low};

    // operation of the current cycle, decoded once the address stage is settled
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op <= pbs_pkg::PBS_OP_IDLE;
        end else if (sleep) begin
            op <= pbs_pkg::PBS_OP_IDLE;
        end else if ((load && sel) || cont) begin
            op <= (|next_wr_bytes) ? pbs_pkg::PBS_OP_WRITE : pbs_pkg::PBS_OP_READ;
        end else begin
            op <= pbs_pkg::PBS_OP_IDLE;
        end
    end

    // write data is taken the edge after the address, so the byte
    // decision may arrive late in the cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_bytes <= '0;
            wr_pend  <= 1'b0;
        end else begin
            wr_pend  <= (!sleep && ((load && sel) || cont)) && (|next_wr_bytes);
            wr_bytes <= next_wr_bytes;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_addr <= '0;
            wr_data <= '0;
        end else begin
            wr_addr <= cur_addr;
            wr_data <= {i_parity_io, i_data_io};
        end
    end

    // second write stage: the burst address and the late data meet here,
    // one edge after the decision, so the array sees a settled word
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_commit <= 1'b0;
            wr_mask   <= '0;
        end else begin
            wr_commit <= wr_pend && !sleep;
            wr_mask   <= wr_bytes;
        end
    end

    // memory write; no reset so contents survive sleep
    always_ff @(posedge i_clk_sys) begin
        for (int b = 0; b < `PBS_BYTES; b++) begin
            if (wr_commit && wr_mask[b] && !sleep) begin
                mem[wr_addr][b*`PBS_LANE_W +: `PBS_LANE_W] <= wr_data[b*`PBS_LANE_W +: `PBS_LANE_W];
                mem[wr_addr][`PBS_DATA_W+b] <= wr_data[`PBS_DATA_W+b];
            end
        end
    end

    // beats stepped since the last load, only for the wrap check
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            beat_cnt <= '0;
        end else if (load) begin
            beat_cnt <= '0;
        end else if (cont && !i_burst_advance_n) begin
            beat_cnt <= beat_cnt + 2'h1;
        end
    end

    // array read has no reset: storage, not control
    always_ff @(posedge i_clk_sys) begin
        rd_word <= mem[cur_addr];
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data_io   <= '0;
            o_parity_io <= '0;
            rd_valid    <= 1'b0;
            selected    <= 1'b0;
        end else if (!sleep) begin
            rd_valid    <= (op == pbs_pkg::PBS_OP_READ);
            selected    <= (op != pbs_pkg::PBS_OP_IDLE);
            o_data_io   <= rd_word[`PBS_DATA_W-1:0];
            o_parity_io <= rd_word[`PBS_WORD_W-1:`PBS_DATA_W];
        end else begin
            rd_valid <= 1'b0;
            selected <= 1'b0;
        end
    end

    // output enable is combinational so it acts without the clock
    assign o_data_oe = !i_output_enable_n && selected && rd_valid && !wr_pend
                       && !sleep;

    AST_PROC_READ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        proc_load && sel && !sleep |=> op == pbs_pkg::PBS_OP_READ)
        else $error("processor strobe cycle not a read");
    AST_GW_ALL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !load && cont && !i_global_write_n |=> wr_pend && wr_bytes == 4'hf)
        else $error("global write did not select all bytes");
    AST_GATE_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cont && i_global_write_n && i_byte_write_gate_n |=> !wr_pend)
        else $error("byte selects passed with gate high");
    AST_OE_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_pend |-> !o_data_oe)
        else $error("outputs driven during write");
    AST_OE_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_output_enable_n |-> !o_data_oe)
        else $error("outputs driven with enable high");
    AST_DESEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        load && !sel && !sleep |=> op == pbs_pkg::PBS_OP_IDLE)
        else $error("deselect did not idle");
    AST_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cont && i_burst_advance_n |=> $stable(low))
        else $error("counter moved with advance high");
    AST_READ_PIPE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        op == pbs_pkg::PBS_OP_READ && !sleep ##1 !sleep |-> rd_valid)
        else $error("read data not one cycle later");
    AST_SLEEP_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        sleep |=> op == pbs_pkg::PBS_OP_IDLE && !o_data_oe)
        else $error("activity during sleep");

    AST_WR_COMMIT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_pend && !sleep
        |=> wr_commit && wr_mask == $past(wr_bytes))
        else $error("write decision not carried to commit");
    AST_SLEEP_NOWR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        sleep
        |=> !wr_commit)
        else $error("write committed during sleep");
    AST_NO_PEND: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !wr_pend
        |=> !wr_commit)
        else $error("commit without pending write");
    AST_BYTE_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !proc_load && i_global_write_n && !i_byte_write_gate_n
        |=> wr_bytes == ~$past(i_byte_select_n))
        else $error("byte selects not passed with gate low");
    AST_GATE_BLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_global_write_n && i_byte_write_gate_n
        |=> wr_bytes == '0)
        else $error("bytes selected with gate and global high");
    AST_GW_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ctrl_load && sel && !sleep && !proc_load && !i_global_write_n
        |=> wr_pend && wr_bytes == 4'hf)
        else $error("global write load did not write all bytes");

    AST_CTRL_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ctrl_load && !sleep
        |=> base == $past(i_addr_in))
        else $error("controller strobe did not load address");
    AST_PROC_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        proc_load && !sleep
        |=> base == $past(i_addr_in))
        else $error("processor strobe did not load address");
    AST_PROC_GATED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ctrl_addr_strobe_n && i_chip_enable_n
        |=> $stable(base))
        else $error("address loaded with enable high");
    AST_LOAD_START: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        load
        |=> low == $past(i_addr_in[`PBS_LOW_W-1:0]))
        else $error("burst did not start at loaded address");
    AST_SEL_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        load && sel
        |=> active)
        else $error("selected load not active");
    AST_DESEL_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        load && !sel
        |=> !active)
        else $error("deselected load left burst active");
    AST_NO_CONT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !active && !load
        |=> op == pbs_pkg::PBS_OP_IDLE)
        else $error("cycle ran without a selected load");

    AST_LIN_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cont && !i_burst_advance_n && i_burst_order_sel == `PBS_ORD_LIN
        |=> low == $past(low) + 2'h1)
        else $error("linear burst step wrong");
    AST_INTLV_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cont && !i_burst_advance_n && i_burst_order_sel == `PBS_ORD_INTLV
        |=> (low ^ base[`PBS_LOW_W-1:0]) == $past(low ^ base[`PBS_LOW_W-1:0]) + 2'h1)
        else $error("interleaved burst step wrong");
    AST_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        active && beat_cnt == 2'h0
        |-> low == base[`PBS_LOW_W-1:0])
        else $error("burst did not wrap to start");
    AST_SLEEP_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        sleep
        |=> $stable(low) && $stable(base))
        else $error("address moved during sleep");

    AST_OE_DESEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !selected
        |-> !o_data_oe)
        else $error("outputs driven while deselected");
    AST_OE_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        rd_valid && !i_output_enable_n && !wr_pend && !sleep
        |-> o_data_oe)
        else $error("outputs not driven for read");
    AST_RD_WORD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        rd_valid
        |-> {o_parity_io, o_data_io} == $past(rd_word))
        else $error("read word not registered to outputs");

    COV_READ: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        op == pbs_pkg::PBS_OP_READ ##1 rd_valid);
    COV_WRITE: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) wr_pend);
    COV_BURST: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cont && !i_burst_advance_n [*3]);
    COV_SLEEP: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        sleep ##1 !sleep);
    COV_INTLV: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cont && !i_burst_advance_n && i_burst_order_sel == `PBS_ORD_INTLV);
endmodule : pbs_sram

//--- pbs_sync3.sv
// three-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pbs_sync3 (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule : pbs_sync3

//--- tb.sv
// self-checking bench for the pipelined burst sram
`timescale 1ns/100ps
`include "pbs_cfg.svh"
module tb;
    logic                   clk, rst_n, cs_hi, cs_lo_n, oe_n, ord, slp, doe, sleeping;
    logic [`PBS_AW-1:0]     addr;
    logic [5:0]             ctl;
    logic [`PBS_BYTES-1:0]  bsel_n;
    logic [`PBS_WORD_W-1:0] wd;
    logic [`PBS_WORD_W-1:0] exp_mem [0:7];
    logic [`PBS_DATA_W-1:0] rd;
    logic [`PBS_PAR_W-1:0]  rp;
    int                     error_cnt, checks_done;
    localparam logic [5:0]  IDL = 6'b011111, LDR = 6'b001111, LDW = 6'b001101;
    localparam logic [5:0]  BYT = 6'b001110, PRW = 6'b010101, BURST_ADVANCE_N = 6'b011011;
    localparam logic [16:0] BASE = 17'h0a5f8;

    pbs_ctrl_model u_pbs_ctrl_model (.i_clk_sys(clk), .o_addr(addr), .o_ctl(ctl),
        .o_bsel_n(bsel_n), .o_wdata(wd));
    pbs_sram u_pbs_sram (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr_in(addr),
        .i_chip_enable_n(ctl[5]), .i_chip_select_hi(cs_hi), .i_chip_select_lo_n(cs_lo_n),
        .i_ctrl_addr_strobe_n(ctl[4]), .i_proc_addr_strobe_n(ctl[3]),
        .i_burst_advance_n(ctl[2]), .i_global_write_n(ctl[1]),
        .i_byte_write_gate_n(ctl[0]), .i_byte_select_n(bsel_n), .i_output_enable_n(oe_n),
        .i_burst_order_sel(ord), .i_sleep_req(slp), .i_data_io(wd[31:0]),
        .i_parity_io(wd[35:32]), .o_data_io(rd), .o_parity_io(rp), .o_data_oe(doe),
        .o_sleeping(sleeping));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cmp_w(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t word %h exp %h", $time, got, exp);
        end
    endtask : cmp_w

    task automatic cmp_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
        end
    endtask : cmp_b

    // order only changes while the device is held in reset
    task automatic do_reset(input logic o);
        rst_n = 1'b0;
        ord   = o;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
    endtask : do_reset

    task automatic wr_all(input logic [35:0] seed);
        for (int j = 0; j < 9; j++) begin
            u_pbs_ctrl_model.cyc(j < 8 ? LDW : IDL, BASE + 17'(j), 4'hf, j > 0, seed + 36'(j));
            if (j > 0) exp_mem[j-1] = seed + 36'(j);
        end
    endtask : wr_all

    // one load then six continue cycles; adv_n bit per each of the first three
    task automatic rd_burst(input logic [2:0] s, input logic [2:0] adv_n, input logic oe);
        logic [1:0] k [0:3];
        logic [1:0] c;
        c    = 2'h0;
        oe_n = oe;
        for (int j = 0; j < 7; j++) begin
            if (j > 0 && j < 4 && !adv_n[j-1]) c++;
            if (j < 4) k[j] = c;
            u_pbs_ctrl_model.cyc(j == 0 ? LDR : (j < 4 && !adv_n[j-1] ? BURST_ADVANCE_N : IDL),
                                 BASE | {14'h0, s}, 4'hf, 1'b0, '0);
            if (j >= 3) begin
                cmp_b(doe, !oe);
                if (!oe) cmp_w({rp, rd}, exp_mem[{s[2], ord ? s[1:0] ^ k[j-3] : s[1:0] + k[j-3]}]);
            end
        end
        oe_n = 1'b0;
    endtask : rd_burst

    // byte 1 gated write, then gate high and processor strobe both stay reads
    task automatic byte_wr;
        logic [35:0] d;
        d = 36'h9_8765_4321;
        u_pbs_ctrl_model.cyc(BYT, BASE | 17'h2, 4'b1101, 1'b0, d);
        u_pbs_ctrl_model.cyc(LDR, BASE | 17'h3, 4'b0000, 1'b1, d);
        u_pbs_ctrl_model.cyc(PRW, BASE | 17'h4, 4'hf, 1'b1, d);
        u_pbs_ctrl_model.cyc(IDL, BASE | 17'h4, 4'hf, 1'b1, d);
        exp_mem[2][15:8] = d[15:8];
        exp_mem[2][33]   = d[33];
    endtask : byte_wr

    task automatic desel;
        cs_hi = 1'b0;
        u_pbs_ctrl_model.cyc(LDR, BASE, 4'hf, 1'b0, '0);
        repeat (3) u_pbs_ctrl_model.cyc(IDL, BASE, 4'hf, 1'b0, '0);
        cmp_b(doe, 1'b0);
        cs_hi = 1'b1;
    endtask : desel

    task automatic sleep_chk;
        slp = 1'b1;
        repeat (6) @(negedge clk);
        cmp_b(sleeping, 1'b1);
        slp = 1'b0;
        repeat (6) @(negedge clk);
        cmp_b(sleeping, 1'b0);
    endtask : sleep_chk

    task final_report;
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // whole run is about 175 cycles, so this only trips on a hang
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        error_cnt   = 0;
        checks_done = 0;
        rst_n       = 1'b0;
        cs_hi       = 1'b1;
        cs_lo_n     = 1'b0;
        oe_n        = 1'b0;
        ord         = 1'b0;
        slp         = 1'b0;
        for (int o = 0; o < 2; o++) begin
            do_reset(o[0]);
            wr_all(36'h5_1234_5670 + 36'(o * 16));
            rd_burst(3'h1, 3'b000, 1'b0);
            rd_burst(3'h6, 3'b010, 1'b0);
            byte_wr();
            rd_burst(3'h1, 3'b000, 1'b0);
            rd_burst(3'h4, 3'b001, 1'b0);
            desel();
            rd_burst(3'h3, 3'b000, 1'b1);
            sleep_chk();
            rd_burst(3'h0, 3'b000, 1'b0);
        end
        final_report();
    end
endmodule : tb
